//--- rtl/mfio_consts.svh
`ifndef MFIO_CONSTS_SVH
`define MFIO_CONSTS_SVH

// port widths
`define P2_W 3
`define P5_W 5
`define PORT_W 8
`define APB_DW 32

// register byte offsets
`define OFS_P2_LATCH 8'h00
`define OFS_P2_PIN 8'h04
`define OFS_P3_LATCH 8'h08
`define OFS_P3_PIN 8'h0c
`define OFS_P4_LATCH 8'h10
`define OFS_P4_PIN 8'h14
`define OFS_P4_DRIVE 8'h18
`define OFS_P5_LATCH 8'h1c
`define OFS_P5_PIN 8'h20
`define OFS_P6_DATA 8'h24
`define OFS_P6_DIR 8'h28
`define OFS_P6_IE 8'h2c
`define OFS_KEY_SEL 8'h30
`define OFS_CTRL 8'h34

// reset values
`define RST_P2_LATCH 3'h7
`define RST_P3_LATCH 8'hff
`define RST_P4_LATCH 8'hff
`define RST_P4_DRIVE 8'h00
`define RST_P5_LATCH 5'h1f
`define RST_P6_LATCH 8'h00
`define RST_P6_DIR 8'h00
`define RST_P6_IE 8'hff
`define RST_KEY_SEL 8'h00
`define RST_DUAL 1'b0
`define RST_GLOBAL_OE 1'b1

// control register fields and special pins
`define CTRL_DUAL_BIT 0
`define CTRL_OE_BIT 1
`define P2_STOP_BIT 0
`define P2_OSC_IN_BIT 1
`define P2_OSC_OUT_BIT 2

`endif

//--- rtl/mfio_pkg.sv
`default_nettype none
package mfio_pkg;

  // decoded register selected by the apb address
  typedef enum logic [3:0] {
    SEL_P2_LATCH = 4'b0000,
    SEL_P2_PIN = 4'b0001,
    SEL_P3_LATCH = 4'b0010,
    SEL_P3_PIN = 4'b0011,
    SEL_P4_LATCH = 4'b0100,
    SEL_P4_PIN = 4'b0101,
    SEL_P4_DRIVE = 4'b0110,
    SEL_P5_LATCH = 4'b0111,
    SEL_P5_PIN = 4'b1000,
    SEL_P6_DATA = 4'b1001,
    SEL_P6_DIR = 4'b1010,
    SEL_P6_IE = 4'b1011,
    SEL_KEY_SEL = 4'b1100,
    SEL_CTRL = 4'b1101,
    SEL_NONE = 4'b1111
  } reg_sel_t;

endpackage
`default_nettype wire

//--- rtl/multi_function_io_ports.sv
`timescale 1ns/100ps
`default_nettype none
`include "mfio_consts.svh"

// What this block does
// R1 - port 2 is three pins, also interrupt, stop release and slow crystal
// R2 - port 2 latch resets to ones; keep one for inputs and other uses
// R3 - dual-clock mode hands two port 2 pins to the slow crystal
// R4 - stop-release pin used as output flags each falling edge
// R5 - port 2 read bits 7 to 3 carry no meaning
// R6 - ports 2 to 5 have separate latch and pin-level read addresses
// R7 - stop mode floats the stop-release pin whatever global enable says
// R8 - port 3 is eight high-current pins, latch resets to ones
// R9 - port 4 latch resets to ones, drive select resets to zero
// R10 - port 4 drive select 0 gives open drain, 1 push-pull
// R11 - port 4 input: software sets latch to one, then clears select
// R12 - port 5 is five pins, latch resets ones, bits 7 to 5 meaningless
// R13 - software keeps port 5 latch one for inputs and bus lines
// R14 - port 6 resets to direction zero, input enable ones, latch zero
// R15 - port 6 direction one drives pin from latch, zero makes input
// R16 - port 6 read: zero, pin level, or latch by direction and enable
// R17 - key wakeup: software clears direction, then sets wakeup select
// R18 - analog input: software clears direction, then input enable
// R19 - software never drives a port 6 pin used as analog input
// R20 - bit operations on mixed-direction ports copy pin levels to latch
// R21 - software avoids port writes and noisy neighbours during conversion
module multi_function_io_ports import mfio_pkg::*; #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [`APB_DW-1:0] pwdata,
  output logic pready,
  output logic pslverr,
  output logic [`APB_DW-1:0] prdata,
  // system side
  input wire logic stop_mode,
  input wire logic slow_osc_out,
  output logic slow_osc_in,
  output logic stop_release_fall,
  output logic key_wakeup,
  output logic [`PORT_W-1:0] analog_select,
  // port 2 pins
  input wire logic [`P2_W-1:0] p2_pin_in,
  output logic [`P2_W-1:0] p2_pin_out,
  output logic [`P2_W-1:0] p2_oe,
  // port 3 pins
  input wire logic [`PORT_W-1:0] p3_pin_in,
  output logic [`PORT_W-1:0] p3_pin_out,
  output logic [`PORT_W-1:0] p3_oe,
  // port 4 pins
  input wire logic [`PORT_W-1:0] p4_pin_in,
  output logic [`PORT_W-1:0] p4_pin_out,
  output logic [`PORT_W-1:0] p4_oe,
  // port 5 pins
  input wire logic [`P5_W-1:0] p5_pin_in,
  output logic [`P5_W-1:0] p5_pin_out,
  output logic [`P5_W-1:0] p5_oe,
  // port 6 pins
  input wire logic [`PORT_W-1:0] p6_pin_in,
  output logic [`PORT_W-1:0] p6_pin_out,
  output logic [`PORT_W-1:0] p6_oe
);

  logic [`P2_W-1:0] port2_out_latch, next_port2_out_latch;
  logic [`PORT_W-1:0] port3_out_latch, next_port3_out_latch;
  logic [`PORT_W-1:0] port4_out_latch, next_port4_out_latch;
  logic [`PORT_W-1:0] port4_drive_select, next_port4_drive_select;
  logic [`P5_W-1:0] port5_out_latch, next_port5_out_latch;
  logic [`PORT_W-1:0] port6_data, next_port6_data;
  logic [`PORT_W-1:0] port6_direction, next_port6_direction;
  logic [`PORT_W-1:0] port6_input_enable, next_port6_input_enable;
  logic [`PORT_W-1:0] key_wakeup_select, next_key_wakeup_select;
  logic dual_clock, next_dual_clock;
  logic global_output_enable, next_global_output_enable;
  logic [`APB_DW-1:0] next_prdata;
  logic stop_prev, next_stop_prev;
  logic next_stop_release_fall;
  logic next_key_wakeup;
  logic [`PORT_W-1:0] p6_read;
  reg_sel_t sel;
  logic wr_en;

  // address decode
  always_comb begin
    unique case (paddr)
      `OFS_P2_LATCH: sel = SEL_P2_LATCH;
      `OFS_P2_PIN: sel = SEL_P2_PIN;
      `OFS_P3_LATCH: sel = SEL_P3_LATCH;
      `OFS_P3_PIN: sel = SEL_P3_PIN;
      `OFS_P4_LATCH: sel = SEL_P4_LATCH;
      `OFS_P4_PIN: sel = SEL_P4_PIN;
      `OFS_P4_DRIVE: sel = SEL_P4_DRIVE;
      `OFS_P5_LATCH: sel = SEL_P5_LATCH;
      `OFS_P5_PIN: sel = SEL_P5_PIN;
      `OFS_P6_DATA: sel = SEL_P6_DATA;
      `OFS_P6_DIR: sel = SEL_P6_DIR;
      `OFS_P6_IE: sel = SEL_P6_IE;
      `OFS_KEY_SEL: sel = SEL_KEY_SEL;
      `OFS_CTRL: sel = SEL_CTRL;
      default: sel = SEL_NONE;
    endcase
  end

  // one wait-free access phase; read data is captured in the setup cycle
  assign pready = psel & penable;
  assign pslverr = psel & penable & (sel == SEL_NONE);
  assign wr_en = psel & penable & pwrite & (sel != SEL_NONE);

  // port 6 read value: input bits return pin or zero, outputs the latch
  assign p6_read = (port6_direction & port6_data) |
    (~port6_direction & port6_input_enable & p6_pin_in); // see R16, R20

  // register next values, read capture and event detection
  always_comb begin
    next_port2_out_latch = port2_out_latch;
    next_port3_out_latch = port3_out_latch;
    next_port4_out_latch = port4_out_latch;
    next_port4_drive_select = port4_drive_select;
    next_port5_out_latch = port5_out_latch;
    next_port6_data = port6_data;
    next_port6_direction = port6_direction;
    next_port6_input_enable = port6_input_enable;
    next_key_wakeup_select = key_wakeup_select;
    next_dual_clock = dual_clock;
    next_global_output_enable = global_output_enable;
    next_prdata = prdata;
    if (psel && !penable) begin
      next_prdata = '0;
      unique case (sel)
        SEL_P2_LATCH: next_prdata[`P2_W-1:0] = port2_out_latch; // see R5, R6
        SEL_P2_PIN: next_prdata[`P2_W-1:0] = p2_pin_in; // see R5, R6
        SEL_P3_LATCH: next_prdata[`PORT_W-1:0] = port3_out_latch; // see R6
        SEL_P3_PIN: next_prdata[`PORT_W-1:0] = p3_pin_in; // see R6
        SEL_P4_LATCH: next_prdata[`PORT_W-1:0] = port4_out_latch;
        SEL_P4_PIN: next_prdata[`PORT_W-1:0] = p4_pin_in;
        SEL_P4_DRIVE: next_prdata[`PORT_W-1:0] = port4_drive_select;
        SEL_P5_LATCH: next_prdata[`P5_W-1:0] = port5_out_latch; // see R12
        SEL_P5_PIN: next_prdata[`P5_W-1:0] = p5_pin_in; // see R12
        SEL_P6_DATA: next_prdata[`PORT_W-1:0] = p6_read; // see R16
        SEL_P6_DIR: next_prdata[`PORT_W-1:0] = port6_direction;
        SEL_P6_IE: next_prdata[`PORT_W-1:0] = port6_input_enable;
        SEL_KEY_SEL: next_prdata[`PORT_W-1:0] = key_wakeup_select;
        SEL_CTRL: begin
          next_prdata[`CTRL_DUAL_BIT] = dual_clock;
          next_prdata[`CTRL_OE_BIT] = global_output_enable;
        end
        SEL_NONE: next_prdata = '0;
      endcase
    end
    if (wr_en) begin
      unique case (sel)
        SEL_P2_LATCH: next_port2_out_latch = pwdata[`P2_W-1:0];
        SEL_P3_LATCH: next_port3_out_latch = pwdata[`PORT_W-1:0];
        SEL_P4_LATCH: next_port4_out_latch = pwdata[`PORT_W-1:0];
        SEL_P4_DRIVE: next_port4_drive_select = pwdata[`PORT_W-1:0];
        SEL_P5_LATCH: next_port5_out_latch = pwdata[`P5_W-1:0];
        SEL_P6_DATA: next_port6_data = pwdata[`PORT_W-1:0];
        SEL_P6_DIR: next_port6_direction = pwdata[`PORT_W-1:0];
        SEL_P6_IE: next_port6_input_enable = pwdata[`PORT_W-1:0];
        SEL_KEY_SEL: next_key_wakeup_select = pwdata[`PORT_W-1:0];
        SEL_CTRL: begin
          next_dual_clock = pwdata[`CTRL_DUAL_BIT];
          next_global_output_enable = pwdata[`CTRL_OE_BIT];
        end
        SEL_P2_PIN, SEL_P3_PIN, SEL_P4_PIN, SEL_P5_PIN, SEL_NONE: ;
      endcase
    end
    // falling edge of the stop-release pin level, driven or not
    next_stop_prev = p2_pin_in[`P2_STOP_BIT];
    next_stop_release_fall = stop_prev & ~p2_pin_in[`P2_STOP_BIT]; // see R4
    // wake while any selected input pin is pulled low
    next_key_wakeup = |(key_wakeup_select & ~port6_direction & ~p6_pin_in);
  end

  // register file and event flops
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      port2_out_latch <= `RST_P2_LATCH; // see R2
      port3_out_latch <= `RST_P3_LATCH; // see R8
      port4_out_latch <= `RST_P4_LATCH; // see R9
      port4_drive_select <= `RST_P4_DRIVE; // see R9
      port5_out_latch <= `RST_P5_LATCH; // see R12
      port6_data <= `RST_P6_LATCH; // see R14
      port6_direction <= `RST_P6_DIR; // see R14
      port6_input_enable <= `RST_P6_IE; // see R14
      key_wakeup_select <= `RST_KEY_SEL;
      dual_clock <= `RST_DUAL;
      global_output_enable <= `RST_GLOBAL_OE;
      prdata <= '0;
      stop_prev <= 1'b1;
      stop_release_fall <= 1'b0;
      key_wakeup <= 1'b0;
    end else begin
      port2_out_latch <= next_port2_out_latch;
      port3_out_latch <= next_port3_out_latch;
      port4_out_latch <= next_port4_out_latch;
      port4_drive_select <= next_port4_drive_select;
      port5_out_latch <= next_port5_out_latch;
      port6_data <= next_port6_data;
      port6_direction <= next_port6_direction;
      port6_input_enable <= next_port6_input_enable;
      key_wakeup_select <= next_key_wakeup_select;
      dual_clock <= next_dual_clock;
      global_output_enable <= next_global_output_enable;
      prdata <= next_prdata;
      stop_prev <= next_stop_prev;
      stop_release_fall <= next_stop_release_fall;
      key_wakeup <= next_key_wakeup;
    end
  end

  // port 2: sink-only drive except crystal output in dual mode; stop pin floats in stop mode; crystal pins
  always_comb begin
    p2_pin_out = port2_out_latch;
    p2_oe = global_output_enable ? ~port2_out_latch : '0; // see R1
    p2_oe[`P2_STOP_BIT] = ~port2_out_latch[`P2_STOP_BIT] &
      (global_output_enable | stop_mode) & ~stop_mode; // see R7
    if (dual_clock) begin
      p2_oe[`P2_OSC_IN_BIT] = 1'b0; // see R3
      p2_pin_out[`P2_OSC_OUT_BIT] = slow_osc_out; // see R3
      p2_oe[`P2_OSC_OUT_BIT] = 1'b1;
    end
  end
  assign slow_osc_in = dual_clock & p2_pin_in[`P2_OSC_IN_BIT]; // see R3

  // ports 3 and 5: sink-only, latch one releases the pin
  assign p3_pin_out = port3_out_latch;
  assign p3_oe = global_output_enable ? ~port3_out_latch : '0; // see R8
  assign p5_pin_out = port5_out_latch;
  assign p5_oe = global_output_enable ? ~port5_out_latch : '0; // see R12

  // port 4: open drain or push-pull per bit
  assign p4_pin_out = port4_out_latch;
  assign p4_oe = global_output_enable ?
    (~port4_out_latch | port4_drive_select) : '0; // see R10

  // port 6: per-bit direction; analog where direction and input enable are both zero
  assign p6_pin_out = port6_data;
  assign p6_oe = global_output_enable ? port6_direction : '0; // see R15
  assign analog_select = ~port6_direction & ~port6_input_enable;

  // checks on the register bus view and the pin drivers
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  // read data is what stood in the setup cycle
  a_p6_read_mux: assert property ( // see R16
    psel && penable && !pwrite && sel == SEL_P6_DATA |->
    prdata[`PORT_W-1:0] == (($past(port6_direction) &
    $past(port6_data)) | (~$past(port6_direction) &
    $past(port6_input_enable) & $past(p6_pin_in))))
    else $error("port 6 read value wrong");
  a_latch_read: assert property ( // see R6
    psel && penable && sel == SEL_P3_LATCH |->
    prdata[`PORT_W-1:0] == $past(port3_out_latch))
    else $error("port 3 latch read wrong");
  a_p2_upper_zero: assert property ( // see R5
    psel && penable && (sel == SEL_P2_LATCH || sel == SEL_P2_PIN) |->
    prdata[`APB_DW-1:`P2_W] == '0)
    else $error("port 2 upper read bits not zero");
  a_p5_upper_zero: assert property ( // see R12
    psel && penable && sel == SEL_P5_PIN |->
    prdata[`APB_DW-1:`P5_W] == '0)
    else $error("port 5 upper read bits not zero");

  // reset values, seen at the first edge after release
  a_reset_ones: assert property ( // see R2
    !$past(arst_n) |->
    &port2_out_latch && &port3_out_latch && &port5_out_latch)
    else $error("latch not ones after reset");
  a_reset_p4_p6: assert property ( // see R14
    !$past(arst_n) |-> port4_drive_select == '0 &&
    port6_direction == '0 && &port6_input_enable && port6_data == '0)
    else $error("port 4 or 6 reset value wrong");

  // pin drivers follow the mode registers
  a_p4_open_drain: assert property ( // see R10
    wr_en && sel == SEL_P4_DRIVE && pwdata[`PORT_W-1:0] == '0 &&
    &port4_out_latch |=> p4_oe == '0)
    else $error("open drain port 4 drives a high");
  a_stop_hiz: assert property ( // see R7
    stop_mode |-> !p2_oe[`P2_STOP_BIT])
    else $error("stop pin driven in stop mode");
  a_stop_fall: assert property ( // see R4
    $fell(p2_pin_in[`P2_STOP_BIT]) |=>
    stop_release_fall ##1 !stop_release_fall)
    else $error("stop pin fall not flagged once");
  a_p6_dir_drive: assert property ( // see R15
    wr_en && sel == SEL_P6_DIR && global_output_enable |=>
    p6_oe == $past(pwdata[`PORT_W-1:0]))
    else $error("port 6 direction not applied");
  a_dual_osc: assert property ( // see R3
    dual_clock |-> !p2_oe[`P2_OSC_IN_BIT] &&
    slow_osc_in == p2_pin_in[`P2_OSC_IN_BIT])
    else $error("crystal pins not released in dual mode");

  // main scenarios
  c_p6_input_read: cover property (psel && penable &&
    sel == SEL_P6_DATA && port6_input_enable[0] && !port6_direction[0]);
  c_stop_fall: cover property (stop_release_fall);
  c_unmapped: cover property (pslverr);
  c_dual_mode: cover property ($rose(dual_clock));
  c_key_wake: cover property ($rose(key_wakeup));

endmodule
`default_nettype wire

//--- tb/mfio_pin_levels.sv
`timescale 1ns/100ps
`default_nettype none

// outside wiring of one port: pin pull-ups plus an outside source
module pin_levels #(
  parameter int W = 8
) (
  // design side of the pins
  input wire logic [W-1:0] drv_val,
  input wire logic [W-1:0] drv_en,
  // outside source
  input wire logic [W-1:0] ext_val,
  input wire logic [W-1:0] ext_en,
  // resolved pin level
  output logic [W-1:0] level
);
  // design drive wins, then the source; a released pin is pulled up
  always_comb begin
    for (int i = 0; i < W; i++) begin
      level[i] = drv_en[i] ? drv_val[i]
        : (ext_en[i] ? ext_val[i] : 1'b1);
    end
  end
endmodule

`default_nettype wire

//--- tb/multi_function_io_ports_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "mfio_consts.svh"

// one counted comparison
`define CHK(nm, ex, gt) begin \
  comparisons++; \
  if ((gt) !== (ex)) begin \
    errors++; \
    $display("mismatch %s expected %h seen %h", nm, ex, gt); \
  end \
end

module multi_function_io_ports_tb;
  int errors = 0;
  int comparisons = 0;
  logic ref_clk, arst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic stop_mode, slow_osc_out, slow_osc_in, stop_release_fall, key_wakeup;
  logic [7:0] analog_select, p3_in, p3_out, p3_oe, p4_in, p4_out, p4_oe;
  logic [7:0] p6_in, p6_out, p6_oe, ext3_val, ext3_en, ext4_val, ext4_en;
  logic [7:0] ext6_val, ext6_en;
  logic [2:0] p2_in, p2_out, p2_oe, ext2_val, ext2_en;
  logic [4:0] p5_in, p5_out, p5_oe, ext5_val, ext5_en;
  logic [3:0] cnt;
  logic e;
  localparam logic [7:0] RA [10] = '{`OFS_P2_LATCH, `OFS_P3_LATCH,
    `OFS_P4_LATCH, `OFS_P4_DRIVE, `OFS_P5_LATCH, `OFS_P6_DATA,
    `OFS_P6_DIR, `OFS_P6_IE, `OFS_KEY_SEL, `OFS_CTRL};
  localparam logic [7:0] RV [10] = '{8'h07, 8'hff, 8'hff, 8'h00, 8'h1f,
    8'hff, 8'h00, 8'hff, 8'h00, 8'h02};

  multi_function_io_ports #(.ADDR_W(8)) u_multi_function_io_ports (
    .ref_clk(ref_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .stop_mode(stop_mode),
    .slow_osc_out(slow_osc_out), .slow_osc_in(slow_osc_in),
    .stop_release_fall(stop_release_fall), .key_wakeup(key_wakeup),
    .analog_select(analog_select),
    .p2_pin_in(p2_in), .p2_pin_out(p2_out), .p2_oe(p2_oe),
    .p3_pin_in(p3_in), .p3_pin_out(p3_out), .p3_oe(p3_oe),
    .p4_pin_in(p4_in), .p4_pin_out(p4_out), .p4_oe(p4_oe),
    .p5_pin_in(p5_in), .p5_pin_out(p5_out), .p5_oe(p5_oe),
    .p6_pin_in(p6_in), .p6_pin_out(p6_out), .p6_oe(p6_oe));

  // pin wiring of each port
  pin_levels #(.W(3)) u_pin_levels_p2 (.drv_val(p2_out), .drv_en(p2_oe),
    .ext_val(ext2_val), .ext_en(ext2_en), .level(p2_in));
  pin_levels #(.W(8)) u_pin_levels_p3 (.drv_val(p3_out), .drv_en(p3_oe),
    .ext_val(ext3_val), .ext_en(ext3_en), .level(p3_in));
  pin_levels #(.W(8)) u_pin_levels_p4 (.drv_val(p4_out), .drv_en(p4_oe),
    .ext_val(ext4_val), .ext_en(ext4_en), .level(p4_in));
  pin_levels #(.W(5)) u_pin_levels_p5 (.drv_val(p5_out), .drv_en(p5_oe),
    .ext_val(ext5_val), .ext_en(ext5_en), .level(p5_in));
  pin_levels #(.W(8)) u_pin_levels_p6 (.drv_val(p6_out), .drv_en(p6_oe),
    .ext_val(ext6_val), .ext_en(ext6_en), .level(p6_in));

  // free-running clock
  always #5 ref_clk = ~ref_clk;

  // one apb transfer: setup, then access until pready
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] rd, output logic er);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    // only the watchdog ends a wait that never sees pready
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    logic y;
    xfer(1'b1, a, d, x, y);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] ex);
    logic [31:0] x;
    logic y;
    xfer(1'b0, a, 32'h0, x, y);
    `CHK("read data", ex, x)
  endtask

  task automatic test_reset();
    for (int i = 0; i < 10; i++) begin
      rdchk(RA[i], {24'h0, RV[i]});
    end
    $display("test reset done");
  endtask

  task automatic test_ports();
    wr(`OFS_P3_LATCH, 32'h5a);
    rdchk(`OFS_P3_PIN, 32'h5a);
    wr(`OFS_P3_PIN, 32'h0);
    rdchk(`OFS_P3_LATCH, 32'h5a);
    `CHK("port3 out", 8'h5a, p3_out)
    @(posedge ref_clk);
    ext3_en <= 8'h02;
    ext3_val <= 8'h00;
    rdchk(`OFS_P3_PIN, 32'h58);
    @(posedge ref_clk);
    ext5_en <= 5'h1f;
    ext5_val <= 5'h0a;
    rdchk(`OFS_P5_PIN, 32'h0a);
    rdchk(`OFS_P5_LATCH, 32'h1f);
    wr(`OFS_P5_LATCH, 32'h15);
    `CHK("port5 enable", 5'h0a, p5_oe)
    `CHK("port5 out", 5'h15, p5_out)
    @(posedge ref_clk);
    ext5_val <= 5'h15;
    rdchk(`OFS_P5_PIN, 32'h15);
    wr(`OFS_P2_LATCH, 32'hffff_fffa);
    rdchk(`OFS_P2_LATCH, 32'h2);
    rdchk(`OFS_P2_PIN, 32'h2);
    $display("test ports done");
  endtask

  task automatic test_p4();
    wr(`OFS_P4_LATCH, 32'h0f);
    wr(`OFS_P4_DRIVE, 32'h33);
    `CHK("port4 enable", 8'hf3, p4_oe)
    `CHK("port4 out", 8'h0f, p4_out)
    wr(`OFS_P4_LATCH, 32'hff);
    wr(`OFS_P4_DRIVE, 32'h0);
    `CHK("port4 enable", 8'h00, p4_oe)
    @(posedge ref_clk);
    ext4_en <= 8'hff;
    ext4_val <= 8'ha5;
    rdchk(`OFS_P4_PIN, 32'ha5);
    $display("test port4 done");
  endtask

  task automatic test_p6();
    @(posedge ref_clk);
    ext6_en <= 8'h0f;
    ext6_val <= 8'h05;
    wr(`OFS_P6_DIR, 32'hf0);
    wr(`OFS_P6_IE, 32'h3c);
    wr(`OFS_P6_DATA, 32'haa);
    `CHK("port6 enable", 8'hf0, p6_oe)
    `CHK("port6 out", 8'haa, p6_out)
    `CHK("analog select", 8'h03, analog_select)
    rdchk(`OFS_P6_DATA, 32'ha4);
    xfer(1'b0, `OFS_P6_DATA, 32'h0, r, e);
    wr(`OFS_P6_DATA, r);
    wr(`OFS_P6_IE, 32'hff);
    wr(`OFS_P6_DIR, 32'hff);
    rdchk(`OFS_P6_DATA, 32'ha4);
    $display("test port6 done");
  endtask

  task automatic test_p2();
    wr(`OFS_CTRL, 32'h3);
    @(posedge ref_clk);
    slow_osc_out <= 1'b1;
    ext2_en <= 3'b010;
    ext2_val <= 3'b000;
    #1;
    `CHK("osc drive", 3'b110, {p2_out[2], p2_oe[2:1]})
    `CHK("osc in", 1'b0, slow_osc_in)
    @(posedge ref_clk);
    ext2_val <= 3'b010;
    #1;
    `CHK("osc in", 1'b1, slow_osc_in)
    @(posedge ref_clk);
    ext2_en <= 3'b000;
    wr(`OFS_CTRL, 32'h2);
    wr(`OFS_P2_LATCH, 32'h7);
    wr(`OFS_P2_LATCH, 32'h6);
    cnt = 4'h0;
    repeat (6) begin
      @(posedge ref_clk);
      #1;
      cnt = cnt + {3'h0, stop_release_fall};
    end
    `CHK("fall pulses", 4'h1, cnt)
    `CHK("port2 enable", 3'b001, p2_oe)
    @(posedge ref_clk);
    stop_mode <= 1'b1;
    #1;
    `CHK("stop float", 3'b000, p2_oe)
    wr(`OFS_CTRL, 32'h0);
    `CHK("port3 enable", 8'h00, p3_oe)
    wr(`OFS_CTRL, 32'h2);
    $display("test port2 done");
  endtask

  task automatic test_key();
    wr(`OFS_P6_DIR, 32'h0);
    wr(`OFS_KEY_SEL, 32'h1);
    @(posedge ref_clk);
    ext6_en <= 8'h01;
    ext6_val <= 8'h00;
    repeat (3) @(posedge ref_clk);
    #1;
    `CHK("key wakeup", 1'b1, key_wakeup)
    @(posedge ref_clk);
    ext6_val <= 8'h01;
    repeat (3) @(posedge ref_clk);
    #1;
    `CHK("key wakeup", 1'b0, key_wakeup)
    xfer(1'b1, 8'h3c, 32'h1, r, e);
    `CHK("unmapped err", 1'b1, e)
    xfer(1'b0, 8'h3c, 32'h0, r, e);
    `CHK("unmapped read", 33'h1_0000_0000, {e, r})
    $display("test key and unmapped done");
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // watchdog against a hang
  initial begin
    repeat (5000) @(posedge ref_clk);
    errors++;
    close_out();
  end

  // main sequence
  initial begin
    ref_clk = 1'b0;
    arst_n = 1'b0;
    {psel, penable, pwrite, stop_mode, slow_osc_out} = 5'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    {ext2_val, ext2_en, ext5_val, ext5_en} = 16'h0;
    {ext3_val, ext3_en, ext4_val, ext4_en, ext6_val, ext6_en} = 48'h0;
    repeat (12) @(posedge ref_clk);
    arst_n <= 1'b1;
    test_reset();
    test_ports();
    test_p4();
    test_p6();
    test_p2();
    test_key();
    close_out();
  end
endmodule

`undef CHK
`default_nettype wire
